// File: rtl/serial_tx_pkg.sv
// Shared constants and carrier types for the secondary serial transmit slot map
package serial_tx_pkg;

    localparam int NUM_CH = 3;
    localparam int SAMPLE_W = 32;
    localparam int CNT_W = 11;
    localparam int HALF_SLOTS = 16;
    localparam int TDM_SLOTS = 32;
    localparam int I2S_DELAY = 1;
    localparam int PADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FMT = 8'h1B;
    localparam logic [7:0] IDX_OFFSET = 8'h1C;
    localparam logic [7:0] IDX_PINSEL = 8'h1D;
    localparam logic [7:0] IDX_CH1 = 8'h1E;
    localparam logic [7:0] IDX_CH2 = 8'h1F;
    localparam logic [7:0] IDX_CH3 = 8'h20;

    localparam logic [PADDR_W-1:0] ADDR_FMT = {2'h0, IDX_FMT, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_OFFSET = {2'h0, IDX_OFFSET, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_PINSEL = {2'h0, IDX_PINSEL, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_CH1 = {2'h0, IDX_CH1, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_CH2 = {2'h0, IDX_CH2, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_CH3 = {2'h0, IDX_CH3, 2'h0};

    localparam logic [7:0] RST_CH1 = 8'h00;
    localparam logic [7:0] RST_CH2 = 8'h01;
    localparam logic [7:0] RST_CH3 = 8'h02;
    localparam logic [7:0] RST_PINSEL = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;

    // Writable bits of each register; everything else reads zero
    localparam logic [7:0] MASK_CH12 = 8'h3F;
    localparam logic [7:0] MASK_CH3 = 8'h7F;
    localparam logic [7:0] MASK_PINSEL = 8'h07;
    localparam logic [7:0] MASK_OFFSET = 8'h1F;
    localparam logic [7:0] MASK_FMT = 8'h03;

    localparam int SRC_BIT = 5;
    localparam int SRC3_HI = 6;
    localparam int SLOT_HI = 4;

    localparam logic [1:0] SRC3_OFF = 2'h0;
    localparam logic [1:0] SRC3_ADC = 2'h1;
    localparam logic [1:0] SRC3_VBAT = 2'h2;

    typedef enum logic [1:0] {
        FMT_TDM,
        FMT_I2S,
        FMT_LEFT_JUSTIFIED,
        FMT_RSVD
    } fmt_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] vbat;
        logic [NUM_CH-1:0][SAMPLE_W-1:0] adc;
    } sample_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic drive;
        logic bit_val;
    } lane_t;

endpackage : serial_tx_pkg

// File: rtl/serial_tx_slot_map.sv
// Secondary serial port transmit slot map with APB register file
//
// Behaviour
// - Reserved upper bits of channel registers read zero; writes to them are dropped.
// - Channel one source bit 5: zero tri-states, one sends converter channel one.
// - Channel two source bit: zero tri-states, one sends converter channel two.
// - Channel three bits 6-5: off, converter three, battery voltage; three reserved.
// - Bits 4-0 of each channel register pick the frame slot.
// - TDM and reserved-format code N is slot N; I2S and left-justified split codes into left and right halves.
// - Channel two register resets to 0x01: off, slot one.
// - Channel three register resets to 0x02: off, slot two.
// - Channel one slot field resets to zero.
// - Per-channel pin bit routes channel to primary or second data output.
// - Five-bit offset delays slot zero MSB by 0 to 31 bit clocks.
module serial_tx_slot_map
    import serial_tx_pkg::*;
#(
    parameter int WORD_BITS = 32
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire apb_req_t apb_i,
    output apb_rsp_t apb_o,
    input wire logic bclk_i,
    input wire logic fsync_i,
    input wire sample_t samples_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic second_data_out_o,
    output logic second_data_out_oe_o
);

    generate
        if (WORD_BITS != 16 && WORD_BITS != 20 && WORD_BITS != 24 && WORD_BITS != 32)
        begin : g_bad_word
            $error("WORD_BITS must be 16, 20, 24 or 32");
        end
    endgenerate

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] cfg;
        logic [NUM_CH-1:0] pinsel;
        logic [4:0] offset;
        fmt_t fmt;
        logic bclk_d;
        logic fsync_d;
        logic [CNT_W-1:0] cnt;
        logic half;
        logic in_frame;
        sample_t samples;
        logic dout;
        logic dout_oe;
        logic sec_dout;
        logic sec_dout_oe;
        logic [31:0] prdata;
    } state_t;

    localparam state_t RST_STATE = '{
        cfg: {RST_CH3, RST_CH2, RST_CH1},
        pinsel: RST_PINSEL[NUM_CH-1:0],
        offset: RST_OFFSET[4:0],
        fmt: FMT_TDM,
        bclk_d: 1'b0,
        fsync_d: 1'b0,
        cnt: '0,
        half: 1'b0,
        in_frame: 1'b0,
        samples: '0,
        dout: 1'b0,
        dout_oe: 1'b0,
        sec_dout: 1'b0,
        sec_dout_oe: 1'b0,
        prdata: 32'h0000_0000
    };

    state_t s_r;
    state_t s_nxt;

    logic setup;
    logic access;
    logic mapped;
    logic [7:0] rd_val;
    logic bclk_rise;
    logic bclk_fall;
    logic fs_rise;
    logic fs_fall;
    logic start_left;
    logic start_right;
    logic [CNT_W-1:0] delay;
    logic [CNT_W-1:0] pos;
    logic [CNT_W-1:0] slot;
    logic [4:0] bitidx;
    logic [4:0] code;
    logic code_valid;
    lane_t [NUM_CH-1:0] lanes;

    assign setup = apb_i.psel && !apb_i.penable;
    assign access = apb_i.psel && apb_i.penable;

    // Read decode; unused bits come back as zero
    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        case (apb_i.paddr)
            ADDR_CH1: begin
                rd_val = s_r.cfg[0] & MASK_CH12;
            end
            ADDR_CH2: begin
                rd_val = s_r.cfg[1] & MASK_CH12;
            end
            ADDR_CH3: begin
                rd_val = s_r.cfg[2] & MASK_CH3;
            end
            ADDR_PINSEL: begin
                rd_val = {5'h00, s_r.pinsel};
            end
            ADDR_OFFSET: begin
                rd_val = {3'h0, s_r.offset};
            end
            ADDR_FMT: begin
                rd_val = {6'h00, s_r.fmt};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign apb_o.prdata = s_r.prdata;
    assign apb_o.pready = access;
    assign apb_o.pslverr = access && !mapped;

    assign bclk_rise = bclk_i && !s_r.bclk_d;
    assign bclk_fall = !bclk_i && s_r.bclk_d;
    assign fs_rise = bclk_rise && fsync_i && !s_r.fsync_d;
    assign fs_fall = bclk_rise && !fsync_i && s_r.fsync_d;

    // Frame and half starts by format; a reserved format behaves as TDM
    always_comb begin
        start_left = fs_rise;
        start_right = 1'b0;
        case (s_r.fmt)
            FMT_I2S: begin
                start_left = fs_fall;
                start_right = fs_rise;
            end
            FMT_LEFT_JUSTIFIED: begin
                start_left = fs_rise;
                start_right = fs_fall;
            end
            default: begin
                start_left = fs_rise;
                start_right = 1'b0;
            end
        endcase
    end

    // slot zero MSB shifted by the programmed offset
    assign delay = CNT_W'(s_r.offset) + ((s_r.fmt == FMT_I2S) ? CNT_W'(I2S_DELAY) : '0);
    assign pos = s_r.cnt - delay;
    assign slot = CNT_W'(pos / CNT_W'(WORD_BITS));
    assign bitidx = 5'(pos % CNT_W'(WORD_BITS));

    always_comb begin
        code = slot[4:0];
        code_valid = 1'b0;
        if (s_r.in_frame && s_r.cnt >= delay) begin
            if (s_r.fmt == FMT_I2S || s_r.fmt == FMT_LEFT_JUSTIFIED) begin
                code_valid = slot < CNT_W'(HALF_SLOTS);
                code = {s_r.half, slot[3:0]};
            end else begin
                code_valid = slot < CNT_W'(TDM_SLOTS);
                code = slot[4:0];
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_lane
            tx_slot_lane #(
                .CHAN(g)
            ) u_lane (
                .cfg_i(s_r.cfg[g]),
                .code_i(code),
                .valid_i(code_valid),
                .bitidx_i(bitidx),
                .samples_i(s_r.samples),
                .lane_o(lanes[g])
            );
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.bclk_d = bclk_i;
        if (setup) begin
            s_nxt.prdata = {24'h000000, rd_val};
        end
        if (access && apb_i.pwrite) begin
            // reserved positions are masked off on write
            case (apb_i.paddr)
                ADDR_CH1: begin
                    s_nxt.cfg[0] = apb_i.pwdata[7:0] & MASK_CH12;
                end
                ADDR_CH2: begin
                    s_nxt.cfg[1] = apb_i.pwdata[7:0] & MASK_CH12;
                end
                ADDR_CH3: begin
                    s_nxt.cfg[2] = apb_i.pwdata[7:0] & MASK_CH3;
                end
                ADDR_PINSEL: begin
                    s_nxt.pinsel = apb_i.pwdata[NUM_CH-1:0];
                end
                ADDR_OFFSET: begin
                    s_nxt.offset = apb_i.pwdata[4:0];
                end
                ADDR_FMT: begin
                    s_nxt.fmt = fmt_t'(apb_i.pwdata[1:0] & MASK_FMT[1:0]);
                end
                default: begin
                    s_nxt.prdata = s_nxt.prdata;
                end
            endcase
        end
        if (bclk_rise) begin
            s_nxt.fsync_d = fsync_i;
            if (start_left || start_right) begin
                s_nxt.cnt = '0;
                s_nxt.half = start_right;
                s_nxt.in_frame = 1'b1;
                if (start_left) begin
                    s_nxt.samples = samples_i;
                end
            end else if (s_r.in_frame && s_r.cnt != '1) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
        if (bclk_fall) begin
            s_nxt.dout_oe = 1'b0;
            s_nxt.sec_dout_oe = 1'b0;
            // route each lane to its pin, lowest channel wins a clash
            for (int i = NUM_CH - 1; i >= 0; i--) begin
                if (lanes[i].drive && s_r.pinsel[i]) begin
                    s_nxt.sec_dout_oe = 1'b1;
                    s_nxt.sec_dout = lanes[i].bit_val;
                end else if (lanes[i].drive) begin
                    s_nxt.dout_oe = 1'b1;
                    s_nxt.dout = lanes[i].bit_val;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout_o = s_r.dout;
    assign dout_oe_o = s_r.dout_oe;
    assign second_data_out_o = s_r.sec_dout;
    assign second_data_out_oe_o = s_r.sec_dout_oe;

    logic all_off;
    assign all_off = !s_r.cfg[0][SRC_BIT] && !s_r.cfg[1][SRC_BIT]
        && (s_r.cfg[2][SRC3_HI:SRC_BIT] == SRC3_OFF || s_r.cfg[2][SRC3_HI:SRC_BIT] == 2'h3);

    sequence apb_setup_s(logic [PADDR_W-1:0] a);
        apb_i.psel && !apb_i.penable && apb_i.paddr == a;
    endsequence

    sequence apb_access_s(logic [PADDR_W-1:0] a);
        apb_i.psel && apb_i.penable && apb_i.paddr == a;
    endsequence

    chk_reserved_read_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        apb_setup_s(ADDR_CH1) ##1 apb_access_s(ADDR_CH1) |-> apb_o.prdata[7:6] == 2'h0
    ) else $error("channel one reserved bits read nonzero");

    chk_ch2_write_mask: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (apb_access_s(ADDR_CH2) and apb_i.pwrite) |=>
            s_r.cfg[1] == {2'h0, $past(apb_i.pwdata[5:0])}
    ) else $error("channel two write not stored masked");

    chk_ch1_write_mask: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (apb_access_s(ADDR_CH1) and apb_i.pwrite) |=>
            s_r.cfg[0] == {2'h0, $past(apb_i.pwdata[5:0])}
    ) else $error("channel one write not stored masked");

    chk_ch3_write_mask: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (apb_access_s(ADDR_CH3) and apb_i.pwrite) |=>
            s_r.cfg[2] == {1'b0, $past(apb_i.pwdata[6:0])}
    ) else $error("channel three write not stored masked");

    chk_pinsel_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (apb_access_s(ADDR_PINSEL) and apb_i.pwrite) |=>
            s_r.pinsel == $past(apb_i.pwdata[NUM_CH-1:0])
    ) else $error("pin select write not stored");

    chk_read_upper_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        access |-> apb_o.prdata[31:8] == 24'h000000
    ) else $error("read data upper bits nonzero");

    chk_ch2_reset_value: assert property (
        @(posedge clk_i) $rose(nrst_i) |-> s_r.cfg[1] == 8'h01
    ) else $error("channel two reset value wrong");

    chk_ch3_reset_value: assert property (
        @(posedge clk_i) $rose(nrst_i) |-> s_r.cfg[2] == 8'h02
    ) else $error("channel three reset value wrong");

    chk_ch1_reset_slot: assert property (
        @(posedge clk_i) $rose(nrst_i) |-> s_r.cfg[0][4:0] == 5'h00
    ) else $error("channel one reset slot nonzero");

    chk_tristate_silent: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (bclk_fall && all_off) |=> !dout_oe_o && !second_data_out_oe_o
    ) else $error("pin driven while every channel is off");

    chk_pin_route: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (bclk_fall && s_r.pinsel == '0) |=> !second_data_out_oe_o
    ) else $error("second data pin driven with no channel routed");

    chk_offset_hold: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (bclk_fall && s_r.cnt < CNT_W'(s_r.offset)) |=> !dout_oe_o && !second_data_out_oe_o
    ) else $error("slot data driven before the offset elapsed");

    chk_unmapped_error: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (access && !mapped) |-> apb_o.pslverr && apb_o.pready && apb_o.prdata == 32'h0000_0000
    ) else $error("unmapped access not flagged");

endmodule : serial_tx_slot_map

// File: rtl/tx_slot_lane.sv
// One transmit channel: source decode and slot match for the current bit
module tx_slot_lane
    import serial_tx_pkg::*;
#(
    parameter int CHAN = 0
) (
    input wire logic [7:0] cfg_i,
    input wire logic [4:0] code_i,
    input wire logic valid_i,
    input wire logic [4:0] bitidx_i,
    input wire sample_t samples_i,
    output lane_t lane_o
);

    generate
        if (CHAN < 0 || CHAN >= NUM_CH) begin : g_bad_chan
            $error("tx_slot_lane CHAN out of range");
        end
    endgenerate

    logic active;
    logic [SAMPLE_W-1:0] word;
    logic [4:0] sel;

    always_comb begin
        active = 1'b0;
        word = samples_i.adc[CHAN];
        if (CHAN == 2) begin
            // three-way source, code 3 stays silent
            case (cfg_i[SRC3_HI:SRC_BIT])
                SRC3_ADC: begin
                    active = 1'b1;
                end
                SRC3_VBAT: begin
                    active = 1'b1;
                    word = samples_i.vbat;
                end
                default: begin
                    active = 1'b0;
                end
            endcase
        end else begin
            // one-bit source for channel one and for channel two
            active = cfg_i[SRC_BIT];
        end
    end

    assign sel = 5'(SAMPLE_W - 1) - bitidx_i;

    // drive only in the slot the channel is assigned to
    // an off channel never drives its slot
    assign lane_o.drive = active && valid_i && (code_i == cfg_i[SLOT_HI:0]);
    assign lane_o.bit_val = word[sel];

endmodule : tx_slot_lane

// File: tb/secondary_serial_tx_slot_map_bench.sv
// Self-checking bench for the secondary serial transmit slot map
module secondary_serial_tx_slot_map_bench;
    import serial_tx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WB = 16;
    localparam int FB = TDM_SLOTS * WB;

    typedef struct packed {
        fmt_t fmt;
        logic [7:0] off;
        logic [7:0] pin;
        logic [2:0][7:0] cfg;
    } row_t;

    localparam row_t ROWS [6] = '{
        '{FMT_TDM, 8'h00, 8'h00, {8'h02, 8'h01, 8'h00}},
        '{FMT_TDM, 8'h00, 8'h00, {8'h3F, 8'h23, 8'h20}},
        '{FMT_TDM, 8'h05, 8'h06, {8'h44, 8'h2A, 8'h21}},
        '{FMT_I2S, 8'h00, 8'h01, {8'h1E, 8'h20, 8'h31}},
        '{FMT_LEFT_JUSTIFIED, 8'h1F, 8'h00, {8'h61, 8'h02, 8'h20}},
        '{FMT_RSVD, 8'h00, 8'h04, {8'h25, 8'h00, 8'h00}}
    };

    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    apb_req_t apb_i = '0;
    apb_rsp_t apb_o;
    sample_t samples_i = {32'h7E81C33C, 32'h5A960FF0, 32'hC3A51E2D, 32'h9D62B04F};
    logic bclk;
    logic fsync;
    logic dout;
    logic dout_oe;
    logic sd;
    logic sd_oe;
    int fail_count = 0;
    int compares = 0;

    always #20 clk_i = ~clk_i;

    serial_tx_slot_map #(.WORD_BITS(WB)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_i),
        .apb_o(apb_o), .bclk_i(bclk), .fsync_i(fsync), .samples_i(samples_i), .dout_o(dout),
        .dout_oe_o(dout_oe), .second_data_out_o(sd), .second_data_out_oe_o(sd_oe));

    serial_host_model #(.FRAME_BITS(FB)) host_u (.clk_i(clk_i), .bclk_o(bclk), .fsync_o(fsync),
        .dout_i(dout), .dout_oe_i(dout_oe), .sd_i(sd), .sd_oe_i(sd_oe));

    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [PADDR_W-1:0] addr, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_i);
        apb_i.psel <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite <= wr;
        apb_i.paddr <= addr;
        apb_i.pwdata <= {24'h0, wd};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (apb_o.pready === 1'b1) break;
        end
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        if (n == 16) begin
            fail_count++;
            $display("Error at %0t: bus answer missing", $time);
            conclude();
        end
    endtask : apb

    task automatic wr(input logic [PADDR_W-1:0] a, input logic [7:0] d, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, exp_err}, "write error flag");
    endtask : wr

    task automatic rdc(input logic [PADDR_W-1:0] a, input logic [7:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h0, exp}, "read data");
        chk({31'h0, e}, {31'h0, exp_err}, "read error flag");
    endtask : rdc

    task automatic run_row(input row_t r);
        int ch;
        int b;
        int base;
        int want [2];
        logic [31:0] seen [2];
        logic [31:0] src;
        logic [1:0] lv;
        logic [1:0] ex;
        logic [1:0] sel3;
        logic on;
        wr(ADDR_FMT, {6'h0, r.fmt}, 1'b0);
        rdc(ADDR_FMT, {6'h0, r.fmt}, 1'b0);
        wr(ADDR_OFFSET, r.off, 1'b0);
        rdc(ADDR_OFFSET, r.off, 1'b0);
        wr(ADDR_PINSEL, r.pin, 1'b0);
        rdc(ADDR_PINSEL, r.pin, 1'b0);
        for (ch = 0; ch < NUM_CH; ch++) begin
            wr(PADDR_W'(ADDR_CH1 + 4 * ch), r.cfg[ch], 1'b0);
            rdc(PADDR_W'(ADDR_CH1 + 4 * ch), r.cfg[ch], 1'b0);
        end
        host_u.run_frame(r.fmt);
        want = '{0, 0};
        seen = '{0, 0};
        for (ch = 0; ch < NUM_CH; ch++) begin
            sel3 = r.cfg[2][SRC3_HI:SRC_BIT];
            on = (ch < 2) ? r.cfg[ch][SRC_BIT] : (sel3 inside {SRC3_ADC, SRC3_VBAT});
            src = (ch == 2 && sel3 == SRC3_VBAT) ? samples_i.vbat : samples_i.adc[ch];
            // A reserved format code frames like TDM
            if (r.fmt inside {FMT_TDM, FMT_RSVD}) begin
                base = r.cfg[ch][4:0] * WB;
            end else begin
                base = r.cfg[ch][4] * (FB / 2) + r.cfg[ch][3:0] * WB;
            end
            base += r.off[4:0] + ((r.fmt == FMT_I2S) ? I2S_DELAY : 0);
            if (on) begin
                want[r.pin[ch]] += WB;
                for (b = 0; b < WB; b++) begin
                    lv = r.pin[ch] ? host_u.cap[base + b][1:0] : host_u.cap[base + b][3:2];
                    ex = {1'b1, src[31 - b]};
                    chk({30'h0, lv}, {30'h0, ex}, "slot bit");
                end
            end
        end
        for (b = 0; b < FB; b++) begin
            seen[0] += host_u.cap[b][3];
            seen[1] += host_u.cap[b][1];
        end
        chk(seen[0], want[0], "driven bits on primary pin");
        chk(seen[1], want[1], "driven bits on second pin");
        $display("Test done: format %0d offset %0d", r.fmt, r.off);
    endtask : run_row

    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        $display("Error at %0t: run too long", $time);
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(ADDR_CH1, 8'h00, 1'b0);
        rdc(ADDR_CH2, 8'h01, 1'b0);
        rdc(ADDR_CH3, 8'h02, 1'b0);
        $display("Test done: reset values");
        for (int i = 0; i < 6; i++) begin
            run_row(ROWS[i]);
        end
        // Reserved bits written on purpose: they must drop and read back zero
        wr(ADDR_CH1, 8'hFF, 1'b0);
        rdc(ADDR_CH1, 8'h3F, 1'b0);
        wr(ADDR_CH2, 8'hC0, 1'b0);
        rdc(ADDR_CH2, 8'h00, 1'b0);
        wr(ADDR_CH3, 8'hFF, 1'b0);
        rdc(ADDR_CH3, 8'h7F, 1'b0);
        wr(12'h0FC, 8'h55, 1'b1);
        rdc(12'h0FC, 8'h00, 1'b1);
        $display("Test done: reserved bits and unmapped address");
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(ADDR_CH1, 8'h00, 1'b0);
        rdc(ADDR_CH2, 8'h01, 1'b0);
        rdc(ADDR_CH3, 8'h02, 1'b0);
        $display("Test done: second reset");
        conclude();
    end

endmodule : secondary_serial_tx_slot_map_bench

// File: tb/serial_host_model.sv
// Host side model: makes the bit and frame clocks and captures both data pins
module serial_host_model
    import serial_tx_pkg::*;
#(
    parameter int FRAME_BITS = 512
) (
    input wire logic clk_i,
    output logic bclk_o,
    output logic fsync_o,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    input wire logic sd_i,
    input wire logic sd_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cap [FRAME_BITS];

    initial begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
    end

    // One bit clock: frame clock moves with the fall, pins are taken at the rise
    task automatic tick(input logic fs, input int idx);
        @(posedge clk_i);
        bclk_o <= 1'b0;
        fsync_o <= fs;
        repeat (3) @(posedge clk_i);
        @(posedge clk_i);
        bclk_o <= 1'b1;
        if (idx >= 0) begin
            cap[idx] = {dout_oe_i, dout_i, sd_oe_i, sd_i};
        end
        @(posedge clk_i);
    endtask : tick

    // Bit clock runs only for a frame plus one leading clock that sets the idle level and one trailing clock that shifts out the last bit
    task automatic run_frame(input fmt_t fmt);
        int r;
        logic fs;
        tick(fmt == FMT_I2S, -1);
        for (r = 0; r <= FRAME_BITS; r++) begin
            case (fmt)
                FMT_I2S: fs = (r >= FRAME_BITS / 2);
                FMT_LEFT_JUSTIFIED: fs = (r < FRAME_BITS / 2);
                default: fs = (r == 0);
            endcase
            tick(fs, r - 1);
        end
        @(posedge clk_i);
        bclk_o <= 1'b0;
    endtask : run_frame

endmodule : serial_host_model
